/* spcs_pkg.sv */
// constants and types for the serial port configuration and status register bank
package spcs_pkg;
	localparam logic [15:0] ADDR_MODULE_CTRL = 16'h0001;
	localparam logic [15:0] ADDR_DBG_RATE_NOW = 16'h0014;
	localparam logic [15:0] ADDR_DBG_FORMAT_NOW = 16'h0015;
	localparam logic [15:0] ADDR_MODE_SELECT = 16'h0016;
	localparam logic [15:0] ADDR_MODE_NOW = 16'h0017;
	localparam logic [15:0] ADDR_SPI_SELECT = 16'h0018;
	localparam logic [15:0] ADDR_SPI_NOW = 16'h0019;
	localparam logic [15:0] ADDR_RATE_SELECT = 16'h001A;
	localparam logic [15:0] MODULE_RESET_CODE = 16'h0003;

	localparam int FMT_PARITY_ON_BIT = 0;
	localparam int FMT_PARITY_ODD_BIT = 1;
	localparam int FMT_TWO_STOP_BIT = 2;

	localparam logic [7:0] DBG_RATE_MIN = 8'h01;
	localparam logic [7:0] DBG_RATE_MAX = 8'h07;
	localparam logic [7:0] DBG_RATE_FALLBACK = 8'h07;
	localparam logic [2:0] DBG_FORMAT_FALLBACK = 3'h0;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_AUTO_CHAIN = 2'h1;
	localparam logic [1:0] MODE_MANUAL_CHAIN = 2'h2;
	localparam logic [1:0] MODE_SPI_SLAVE = 2'h3;
	localparam logic [7:0] MODE_ERROR_CODE = 8'h04;
	localparam logic [1:0] MODE_RESET = MODE_AUTO_CHAIN;

	localparam logic [2:0] SPI_MIN = 3'h1;
	localparam logic [2:0] SPI_MAX = 3'h4;
	localparam logic [2:0] SPI_MASTER_FIXED = 3'h4;
	localparam logic [2:0] SPI_RESET = 3'h4;
	localparam logic [2:0] SPI_DEACTIVATED = 3'h0;

	localparam logic [1:0] RATE_OFF = 2'h0;
	localparam logic [1:0] RATE_RESET = 2'h1;

	typedef enum logic [1:0] {
		SPCS_RUN,
		SPCS_APPLY
	} spcs_state_t;

	// spi code to phase (bit 1) and polarity (bit 0)
	function automatic logic [1:0] spi_code_to_pha_pol(input logic [2:0] code);
		logic [2:0] idx;
		idx = code - 3'h1;
		return idx[1:0];
	endfunction : spi_code_to_pha_pol
endpackage : spcs_pkg

/* spcs_cfg_if.sv */
// carrier between the register bank and its settings holder
`timescale 1ns/10ps
interface spcs_cfg_if;
	logic apply;
	logic [7:0] sel_dbg_rate;
	logic [2:0] sel_dbg_format;
	logic [1:0] sel_mode;
	logic [2:0] sel_spi;
	logic [1:0] sel_rate;
	logic [7:0] now_dbg_rate;
	logic [2:0] now_dbg_format;
	logic [1:0] now_mode;
	logic [2:0] now_spi;
	logic [1:0] now_rate;

	modport bank (output apply, sel_dbg_rate, sel_dbg_format, sel_mode, sel_spi, sel_rate,
		input now_dbg_rate, now_dbg_format, now_mode, now_spi, now_rate);
	modport holder (input apply, sel_dbg_rate, sel_dbg_format, sel_mode, sel_spi, sel_rate,
		output now_dbg_rate, now_dbg_format, now_mode, now_spi, now_rate);
endinterface : spcs_cfg_if

/* spcs_active_set.sv */
// settings in force, latched from the written configuration on each apply
`timescale 1ns/10ps
module spcs_active_set (
	input wire logic sys_clk_i, // system clock
	input wire logic reset_i, // sync reset, active high
	input wire logic clk_en_i, // clock enable
	spcs_cfg_if.holder cfg // configuration carrier
);
	logic dbg_rate_ok;
	assign dbg_rate_ok = (cfg.sel_dbg_rate >= spcs_pkg::DBG_RATE_MIN) &&
		(cfg.sel_dbg_rate <= spcs_pkg::DBG_RATE_MAX);

	// debug port: invalid rate falls back to the safe format so the port stays reachable
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cfg.now_dbg_rate <= spcs_pkg::DBG_RATE_FALLBACK;
			cfg.now_dbg_format <= spcs_pkg::DBG_FORMAT_FALLBACK;
		end else if (clk_en_i && cfg.apply) begin
			if (dbg_rate_ok) begin
				cfg.now_dbg_rate <= cfg.sel_dbg_rate;
				cfg.now_dbg_format <= cfg.sel_dbg_format;
			end else begin
				cfg.now_dbg_rate <= spcs_pkg::DBG_RATE_FALLBACK;
				cfg.now_dbg_format <= spcs_pkg::DBG_FORMAT_FALLBACK;
			end
		end
	end

	// sync port mode, spi setting and rate
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cfg.now_mode <= spcs_pkg::MODE_RESET;
			cfg.now_spi <= spcs_pkg::SPI_MASTER_FIXED;
			cfg.now_rate <= spcs_pkg::RATE_RESET;
		end else if (clk_en_i && cfg.apply) begin
			cfg.now_mode <= cfg.sel_mode;
			cfg.now_rate <= cfg.sel_rate;
			if (cfg.sel_mode == spcs_pkg::MODE_OFF || cfg.sel_rate == spcs_pkg::RATE_OFF) begin
				cfg.now_spi <= spcs_pkg::SPI_DEACTIVATED;
			end else if (cfg.sel_mode == spcs_pkg::MODE_SPI_SLAVE) begin
				cfg.now_spi <= cfg.sel_spi;
			end else begin
				cfg.now_spi <= spcs_pkg::SPI_MASTER_FIXED;
			end
		end
	end
endmodule : spcs_active_set

/* spcs_regs.sv */
// serial port configuration and status register bank, top level
`timescale 1ns/10ps
module spcs_regs (
	input wire logic sys_clk_i, // system clock, 100 MHz
	input wire logic reset_i, // sync reset, active high
	input wire logic clk_en_i, // freezes all state while low
	input wire logic [15:0] reg_addr_i, // register number
	input wire logic reg_wr_i, // write strobe
	input wire logic [15:0] reg_wdata_i, // write data
	input wire logic reg_rd_i, // read strobe
	output logic [15:0] reg_rdata_o, // read data, registered
	output logic reg_rvalid_o, // read data valid pulse
	output logic reg_err_o, // unmapped or read-only write, pulse
	input wire logic [7:0] dbg_rate_cfg_i, // stored debug-port rate setting
	input wire logic [2:0] dbg_format_cfg_i, // stored debug-port format setting
	input wire logic chain_error_i, // shift chain master in error state
	output logic module_reset_o, // pulse: module reset requested
	output logic [1:0] sync_mode_o, // mode in force
	output logic spi_phase_o, // spi phase in force
	output logic spi_polarity_o, // spi polarity in force
	output logic [1:0] sync_rate_o, // sync-port rate in force
	output logic port_active_o // sync port running
);
	spcs_cfg_if cfg ();

	logic [1:0] mode_select;
	logic [2:0] spi_select;
	logic [1:0] rate_select;
	logic apply_pending;
	logic [7:0] mode_now;
	logic [15:0] next_rdata;
	logic next_err;

	// writable configuration; out-of-range codes are refused and leave the value alone
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_select <= spcs_pkg::MODE_RESET;
			spi_select <= spcs_pkg::SPI_RESET;
			rate_select <= spcs_pkg::RATE_RESET;
		end else if (clk_en_i && reg_wr_i) begin
			unique case (reg_addr_i)
				spcs_pkg::ADDR_MODE_SELECT: begin
					if (reg_wdata_i <= 16'h0003) begin
						mode_select <= reg_wdata_i[1:0];
					end
				end
				spcs_pkg::ADDR_SPI_SELECT: begin
					if (reg_wdata_i >= 16'(spcs_pkg::SPI_MIN) &&
						reg_wdata_i <= 16'(spcs_pkg::SPI_MAX)) begin
						spi_select <= reg_wdata_i[2:0];
					end
				end
				spcs_pkg::ADDR_RATE_SELECT: begin
					if (reg_wdata_i <= 16'h0003) begin
						rate_select <= reg_wdata_i[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// module reset command; applies one cycle after the command, and also after power-up
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			apply_pending <= 1'b1;
		end else if (clk_en_i) begin
			apply_pending <= reg_wr_i && reg_addr_i == spcs_pkg::ADDR_MODULE_CTRL &&
				reg_wdata_i == spcs_pkg::MODULE_RESET_CODE;
		end
	end

	assign cfg.apply = apply_pending;
	assign cfg.sel_dbg_rate = dbg_rate_cfg_i;
	assign cfg.sel_dbg_format = dbg_format_cfg_i;
	assign cfg.sel_mode = mode_select;
	assign cfg.sel_spi = spi_select;
	assign cfg.sel_rate = rate_select;

	spcs_active_set u_active (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.cfg(cfg)
	);

	// error code only overrides the chain master modes
	always_comb begin
		if (chain_error_i && (cfg.now_mode == spcs_pkg::MODE_AUTO_CHAIN ||
			cfg.now_mode == spcs_pkg::MODE_MANUAL_CHAIN)) begin
			mode_now = spcs_pkg::MODE_ERROR_CODE;
		end else begin
			mode_now = {6'h00, cfg.now_mode};
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		next_err = 1'b0;
		unique case (reg_addr_i)
			spcs_pkg::ADDR_DBG_RATE_NOW: next_rdata = {8'h00, cfg.now_dbg_rate};
			spcs_pkg::ADDR_DBG_FORMAT_NOW: begin
				next_rdata[spcs_pkg::FMT_PARITY_ON_BIT] =
					cfg.now_dbg_format[spcs_pkg::FMT_PARITY_ON_BIT];
				next_rdata[spcs_pkg::FMT_PARITY_ODD_BIT] =
					cfg.now_dbg_format[spcs_pkg::FMT_PARITY_ODD_BIT];
				next_rdata[spcs_pkg::FMT_TWO_STOP_BIT] =
					cfg.now_dbg_format[spcs_pkg::FMT_TWO_STOP_BIT];
			end
			spcs_pkg::ADDR_MODE_SELECT: next_rdata = {14'h0000, mode_select};
			spcs_pkg::ADDR_MODE_NOW: next_rdata = {8'h00, mode_now};
			spcs_pkg::ADDR_SPI_SELECT: next_rdata = {13'h0000, spi_select};
			spcs_pkg::ADDR_SPI_NOW: next_rdata = {13'h0000, cfg.now_spi};
			spcs_pkg::ADDR_RATE_SELECT: next_rdata = {14'h0000, rate_select};
			default: next_err = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else if (clk_en_i) begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// write to a read-only or unknown register, or read of an unknown one
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_err_o <= 1'b0;
		end else if (clk_en_i) begin
			reg_err_o <= (reg_rd_i && next_err) || (reg_wr_i &&
				reg_addr_i != spcs_pkg::ADDR_MODE_SELECT &&
				reg_addr_i != spcs_pkg::ADDR_SPI_SELECT &&
				reg_addr_i != spcs_pkg::ADDR_RATE_SELECT &&
				reg_addr_i != spcs_pkg::ADDR_MODULE_CTRL);
		end
	end

	assign module_reset_o = apply_pending;
	assign sync_mode_o = cfg.now_mode;
	assign {spi_phase_o, spi_polarity_o} = (cfg.now_spi == spcs_pkg::SPI_DEACTIVATED) ?
		2'h3 : spcs_pkg::spi_code_to_pha_pol(cfg.now_spi);
	assign sync_rate_o = cfg.now_rate;
	assign port_active_o = cfg.now_spi != spcs_pkg::SPI_DEACTIVATED;
endmodule : spcs_regs

/* spcs_regs_asserts.sv */
// port assertions for the register bank
`timescale 1ns/10ps
module spcs_regs_asserts (
	input wire logic sys_clk_i, // clock
	input wire logic reset_i, // reset
	input wire logic clk_en_i, // enable
	input wire logic [15:0] reg_addr_i, // address
	input wire logic reg_wr_i, // write
	input wire logic [15:0] reg_wdata_i, // data
	input wire logic reg_rd_i, // read
	input wire logic [15:0] reg_rdata_o, // read data
	input wire logic reg_rvalid_o, // valid
	input wire logic reg_err_o, // error
	input wire logic module_reset_o, // apply
	input wire logic [1:0] sync_mode_o, // mode
	input wire logic spi_phase_o, // phase
	input wire logic spi_polarity_o, // polarity
	input wire logic [1:0] sync_rate_o // rate
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	chk_read_answered: assert property (clk_en_i && reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	chk_valid_pulse: assert property (clk_en_i && !reg_rd_i |=> !reg_rvalid_o)
		else $error("stray read valid");
	chk_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	chk_ro_write_err: assert property (clk_en_i && reg_wr_i
		&& reg_addr_i inside {16'h0014, 16'h0015, 16'h0017, 16'h0019} |=> reg_err_o)
		else $error("read-only write not flagged");
	chk_unmapped_err: assert property (clk_en_i && reg_rd_i
		&& !(reg_addr_i inside {[16'h0014:16'h001A]}) |=> reg_err_o) else $error("bad read");
	chk_apply_cmd: assert property (clk_en_i && reg_wr_i && reg_addr_i == 16'h0001
		&& reg_wdata_i == 16'h0003 |=> module_reset_o) else $error("apply missing");
	// mode and rate in force may only move at an apply
	chk_hold_settings: assert property (
		!module_reset_o |=> $stable({sync_mode_o, sync_rate_o})) else $error("setting moved");
	chk_master_fixed: assert property (
		sync_mode_o != 2'h3 |-> spi_phase_o && spi_polarity_o) else $error("spi not fixed");
	cover property (module_reset_o);
	cover property (reg_err_o);
	cover property (sync_mode_o == 2'h3 && !spi_phase_o);
endmodule : spcs_regs_asserts
bind spcs_regs spcs_regs_asserts i_spcs_regs_asserts (.sys_clk_i, .reset_i, .clk_en_i,
	.reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_err_o,
	.module_reset_o, .sync_mode_o, .spi_phase_o, .spi_polarity_o, .sync_rate_o);

/* spcs_host_model.sv */
// host model: one-cycle read and write strobes on the register bus
`timescale 1ns/10ps
module spcs_host_model (
	input wire logic sys_clk_i, // clock
	input wire logic [15:0] reg_rdata_i, // read data
	input wire logic reg_rvalid_i, // valid
	input wire logic reg_err_i, // error
	output logic [15:0] reg_addr_o = 16'h0000, // address
	output logic reg_wr_o = 1'b0, // write
	output logic [15:0] reg_wdata_o = 16'h0000, // data
	output logic reg_rd_o = 1'b0 // read
);
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic v, e);
		@(negedge sys_clk_i);
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
		@(negedge sys_clk_i);
		// released lines show the inverse, not a stale copy
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'h0, ~a, ~d};
		{q, v, e} = {reg_rdata_i, reg_rvalid_i, reg_err_i};
	endtask : xfer
endmodule : spcs_host_model

/* test_spcs_regs.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
module test_spcs_regs;
	typedef struct packed {logic [1:0] md; logic [2:0] sp; logic [1:0] rt; logic ce;
		logic [7:0] dr; logic [2:0] df, xm, xs; logic [1:0] xpp;} spcs_row_t;
	logic sys_clk_i = 1'b0, reset_i = 1'b1, chain_error_i = 1'b0, clk_en_i = 1'b1, ok;
	logic port_active_o;
	logic [7:0] dbg_rate_cfg_i = 8'h07;
	logic [2:0] dbg_format_cfg_i = 3'h0;
	logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
	logic reg_wr_i, reg_rd_i, reg_rvalid_o, reg_err_o, module_reset_o, spi_phase_o, spi_polarity_o, v, e;
	logic [1:0] sync_mode_o, sync_rate_o;
	int bad_count = 0, samples_checked = 0;
	spcs_row_t r;
	spcs_row_t rows [8] = '{
		'{2'h3, 3'h1, 2'h1, 1'h1, 8'h01, 3'h5, 3'h3, 3'h1, 2'h0},
		'{2'h3, 3'h2, 2'h2, 1'h0, 8'h07, 3'h3, 3'h3, 3'h2, 2'h1},
		'{2'h3, 3'h3, 2'h3, 1'h0, 8'h04, 3'h6, 3'h3, 3'h3, 2'h2},
		'{2'h1, 3'h1, 2'h1, 1'h1, 8'h02, 3'h1, 3'h4, 3'h4, 2'h3},
		'{2'h2, 3'h2, 2'h1, 1'h1, 8'h03, 3'h2, 3'h4, 3'h4, 2'h3},
		'{2'h0, 3'h3, 2'h1, 1'h1, 8'h05, 3'h4, 3'h0, 3'h0, 2'h3},
		'{2'h3, 3'h4, 2'h0, 1'h0, 8'h09, 3'h7, 3'h3, 3'h0, 2'h3},
		'{2'h3, 3'h4, 2'h1, 1'h0, 8'h06, 3'h0, 3'h3, 3'h4, 2'h3}};
	spcs_regs i_spcs_regs (.sys_clk_i, .reset_i, .clk_en_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_err_o, .dbg_rate_cfg_i,
		.dbg_format_cfg_i, .chain_error_i, .module_reset_o, .sync_mode_o, .spi_phase_o,
		.spi_polarity_o, .sync_rate_o, .port_active_o);
	spcs_host_model i_spcs_host_model (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
		.reg_rvalid_i(reg_rvalid_o), .reg_err_i(reg_err_o), .reg_addr_o(reg_addr_i),
		.reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input string n, input logic [15:0] x, g);
		samples_checked++;
		if (g !== x) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// for reads d is the expected data
	task automatic acc(input logic w, input logic [15:0] a, d, input logic xe);
		i_spcs_host_model.xfer(w, a, d, q, v, e);
		chk("err", {15'h0, xe}, {15'h0, e});
		if (!w && !xe) begin
			chk("rvalid", 16'h0001, {15'h0, v});
			chk("rdata", d, q);
		end
	endtask : acc
	task automatic reset_seq;
		reset_i = 1'b1;
		repeat (20) @(negedge sys_clk_i);
		reset_i = 1'b0;
		acc(1'b0, 16'h0016, 16'h0001, 1'b0);
		acc(1'b0, 16'h0017, 16'h0001, 1'b0);
		acc(1'b0, 16'h0018, 16'h0004, 1'b0);
		acc(1'b0, 16'h0019, 16'h0004, 1'b0);
		acc(1'b0, 16'h001A, 16'h0001, 1'b0);
	endtask : reset_seq
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	initial begin
		reset_seq();
		foreach (rows[i]) begin
			r = rows[i];
			ok = r.dr inside {[8'h01:8'h07]};
			acc(1'b1, 16'h0016, {14'h0, r.md}, 1'b0);
			acc(1'b1, 16'h0018, {13'h0, r.sp}, 1'b0);
			acc(1'b1, 16'h001A, {14'h0, r.rt}, 1'b0);
			{chain_error_i, dbg_rate_cfg_i, dbg_format_cfg_i} = {r.ce, r.dr, r.df};
			acc(1'b1, 16'h0001, 16'h0003, 1'b0);
			chk("apply", 16'h0001, {15'h0, module_reset_o});
			acc(1'b0, 16'h0017, {13'h0, r.xm}, 1'b0);
			acc(1'b0, 16'h0019, {13'h0, r.xs}, 1'b0);
			acc(1'b0, 16'h0014, {8'h0, ok ? r.dr : 8'h07}, 1'b0);
			acc(1'b0, 16'h0015, {13'h0, ok ? r.df : 3'h0}, 1'b0);
			chk("spi", {14'h0, r.xpp}, {14'h0, spi_phase_o, spi_polarity_o});
			chk("rate", {14'h0, r.rt}, {14'h0, sync_rate_o});
			chk("mode", {13'h0, r.md, r.xs != 3'h0}, {13'h0, sync_mode_o, port_active_o});
		end
		acc(1'b1, 16'h0016, 16'h0004, 1'b0);
		acc(1'b1, 16'h0018, 16'h0005, 1'b0);
		acc(1'b1, 16'h001A, 16'h0004, 1'b0);
		acc(1'b1, 16'h0017, 16'h0002, 1'b1);
		acc(1'b0, 16'h001B, 16'h0000, 1'b1);
		// a write while the enable is low must leave the select untouched
		clk_en_i = 1'b0;
		i_spcs_host_model.xfer(1'b1, 16'h0016, 16'h0000, q, v, e);
		clk_en_i = 1'b1;
		acc(1'b0, 16'h001A, 16'h0001, 1'b0);
		acc(1'b0, 16'h0016, 16'h0003, 1'b0);
		acc(1'b0, 16'h0018, 16'h0004, 1'b0);
		acc(1'b0, 16'h0017, 16'h0003, 1'b0);
		reset_seq();
		results();
	end
endmodule : test_spcs_regs
